// ==== fcr_pkg.sv ====
// shared constants for the flash controller register front end
package fcr_pkg;
	// ==================== register byte addresses ====================
	localparam logic [23:0] FCR_ADDR_CMD_STAT = 24'hFFE060;
	localparam logic [23:0] FCR_ADDR_ACCESS = 24'hFFE061;
	localparam logic [23:0] FCR_ADDR_GUARD = 24'hFFE062;
	localparam logic [23:0] FCR_ADDR_PAGE = 24'hFFE064;
	// ==================== command codes ====================
	localparam logic [7:0] FCR_CMD_UNLOCK1 = 8'h73;
	localparam logic [7:0] FCR_CMD_UNLOCK2 = 8'h8C;
	localparam logic [7:0] FCR_CMD_PAGE_ERASE = 8'h95;
	localparam logic [7:0] FCR_CMD_MASS_ERASE = 8'h63;
	localparam logic [7:0] FCR_CMD_LOCK = 8'h00;
	// ==================== field positions and reset values ====================
	localparam int FCR_UNLOCK_BIT = 7;
	localparam int FCR_SIDE_AREA_BIT = 7;
	localparam int FCR_PAGE_LSB = 3;
	localparam int FCR_PAGE_W = 6;
	localparam int FCR_ADDR_PAGE_LSB = 11;
	localparam logic [7:0] FCR_GUARD_RST = 8'h00;
	localparam logic [5:0] FCR_PAGE_RST = 6'h00;
	localparam logic [5:0] FCR_STATE_IDLE = 6'h00;
	localparam logic [5:0] FCR_STATE_PROG = 6'h08;
	localparam logic [5:0] FCR_STATE_PERASE = 6'h10;
	localparam logic [5:0] FCR_STATE_MERASE = 6'h20;
	localparam logic [23:0] FCR_SIDE_AREA_TOP = 24'h00007F;
	localparam logic [15:0] FCR_ERASED_WORD = 16'hFFFF;
	// ==================== controller states ====================
	typedef enum logic [2:0] {
		FCR_LOCKED = 3'b000,
		FCR_HALF = 3'b001,
		FCR_OPEN = 3'b011,
		FCR_PERASE = 3'b010,
		FCR_MERASE = 3'b110,
		FCR_PROG = 3'b111
	} fcr_state_t;
endpackage

// ==== fcr_flash_regs.sv ====
// register front end and command sequencer of the flash controller
`timescale 1ns/1ps
module fcr_flash_regs
	import fcr_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int SECTOR_PAGES_LOG2 = 3
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// avalon-mm slave, byte addressed, 16-bit data
	input wire logic [ADDR_W-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [1:0] i_byteenable,
	input wire logic [15:0] i_writedata,
	output logic [15:0] o_readdata,
	output logic o_waitrequest,
	// cpu program memory write request
	input wire logic i_mem_wr,
	input wire logic [ADDR_W-1:0] i_mem_addr,
	input wire logic [15:0] i_mem_data,
	// program memory read address for the side area overlay
	input wire logic [ADDR_W-1:0] i_fetch_addr,
	// flash array side
	input wire logic i_array_done,
	output logic o_array_prog,
	output logic o_array_page_erase,
	output logic o_array_mass_erase,
	output logic [ADDR_W-1:0] o_array_addr,
	output logic [15:0] o_array_data,
	output logic [5:0] o_array_page,
	output logic o_side_area_hit,
	output logic o_busy
);
	// ==================== state ====================
	fcr_state_t state;
	fcr_state_t next_state;
	logic side_area_select;
	logic [7:0] sector_guard;
	logic [FCR_PAGE_W-1:0] target_page;
	logic access_taken;
	// sector number is the page number without its low bits
	localparam int SECT_W = FCR_PAGE_W - SECTOR_PAGES_LOG2;

	// ==================== decode ====================
	logic req;
	logic hit_cmd;
	logic hit_access;
	logic hit_guard;
	logic hit_page;
	logic cmd_wr;
	logic page_wr;
	// write strobes, each valid at the answering edge
	logic wr_go;
	logic access_wr;
	logic guard_wr;
	// derived flags
	logic unlocked;
	logic op_next;
	logic any_guard;
	logic side_hit_next;
	logic [15:0] next_readdata;
	logic page_guarded;
	logic mem_guarded;
	logic mem_in_page;
	logic [7:0] cmd;
	logic [7:0] status_byte;
	logic [5:0] state_field;

	assign req = (i_read | i_write) & ~access_taken;
	// bytes of the 16-bit bus: even address uses low lane
	assign hit_cmd = i_address == FCR_ADDR_CMD_STAT;
	assign hit_access = i_address == FCR_ADDR_ACCESS;
	assign hit_guard = i_address == FCR_ADDR_GUARD;
	assign hit_page = i_address == FCR_ADDR_PAGE;
	assign cmd = i_writedata[7:0];

	// writes land only at the edge that answers them
	assign wr_go = i_write & ~o_waitrequest;
	assign cmd_wr = wr_go & hit_cmd & i_byteenable[0];
	assign page_wr = wr_go & hit_page & i_byteenable[0];
	assign access_wr = wr_go & hit_access & i_byteenable[1];
	assign guard_wr = wr_go & hit_guard & i_byteenable[0];
	// sector of the selected page is upper bits of page number
	assign page_guarded =
		sector_guard[target_page[FCR_PAGE_W-1 -: SECT_W]];
	assign mem_guarded =
		sector_guard[i_mem_addr[FCR_ADDR_PAGE_LSB+FCR_PAGE_W-1 -: SECT_W]];
	// page match on address bits 16:11
	assign mem_in_page =
		i_mem_addr[FCR_ADDR_PAGE_LSB +: FCR_PAGE_W] == target_page;
	// mass erase needs every sector open
	assign any_guard = |sector_guard;

	// one wait cycle per access, then the answer
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			access_taken <= 1'b0;
		end else begin
			access_taken <= req;
		end
	end

	// ==================== command sequencer ====================
	always_comb begin
		next_state = state;
		unique case (state)
			FCR_LOCKED: begin
				if (cmd_wr && cmd == FCR_CMD_UNLOCK1) begin
					next_state = FCR_HALF;
				end
			end
			FCR_HALF: begin
				if (cmd_wr) begin
					next_state = (cmd == FCR_CMD_UNLOCK2) ? FCR_OPEN : FCR_LOCKED;
				end else if (page_wr) begin
					next_state = FCR_LOCKED;
				end
			end
			FCR_OPEN: begin
				if (cmd_wr) begin
					if (cmd == FCR_CMD_PAGE_ERASE && !page_guarded) begin
						next_state = FCR_PERASE;
					end else if (cmd == FCR_CMD_MASS_ERASE && !any_guard) begin
						next_state = FCR_MERASE;
					end else begin
						next_state = FCR_LOCKED;
					end
				end else if (page_wr) begin
					next_state = FCR_LOCKED;
				end else if (i_mem_wr && mem_in_page && !mem_guarded) begin
					next_state = FCR_PROG;
				end
			end
			FCR_PROG: begin
				// commands are ignored until the array reports done
				if (i_array_done) begin
					next_state = FCR_OPEN;
				end
			end
			FCR_PERASE: begin
				// erase runs to the end, then relocks
				if (i_array_done) begin
					next_state = FCR_LOCKED;
				end
			end
			FCR_MERASE: begin
				// whole array erase, then relocks
				if (i_array_done) begin
					next_state = FCR_LOCKED;
				end
			end
			default: next_state = FCR_LOCKED;
		endcase
	end

	// state register; reads never enter here
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			state <= FCR_LOCKED;
		end else begin
			state <= next_state;
		end
	end

	// ==================== registers ====================
	// side area select, reserved bits kept zero
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			side_area_select <= 1'b0;
		end else if (access_wr) begin
			side_area_select <= i_writedata[8 + FCR_SIDE_AREA_BIT];
		end
	end

	// sector guard, set only
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			sector_guard <= FCR_GUARD_RST;
		end else if (guard_wr) begin
			sector_guard <= sector_guard | i_writedata[7:0];
		end
	end

	// page field only, reserved bits not stored
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			target_page <= FCR_PAGE_RST;
		end else if (page_wr) begin
			target_page <= i_writedata[FCR_PAGE_LSB +: FCR_PAGE_W];
		end
	end

	// ==================== status and read data ====================
	always_comb begin
		unique case (state)
			FCR_PROG: state_field = FCR_STATE_PROG;
			FCR_PERASE: state_field = FCR_STATE_PERASE;
			FCR_MERASE: state_field = FCR_STATE_MERASE;
			default: state_field = FCR_STATE_IDLE;
		endcase
	end

	// unlocked once both unlock codes are in, also while working
	assign unlocked = state != FCR_LOCKED && state != FCR_HALF;

	// unlock bit, zero reserved bit, state field
	assign status_byte = {unlocked, 1'b0, state_field};

	// read data of the addressed register
	always_comb begin
		// unmapped addresses read zero
		next_readdata = 16'h0000;
		if (hit_cmd) begin
			next_readdata = {8'h00, status_byte};
		end else if (hit_access) begin
			next_readdata = {side_area_select, 7'h00, 8'h00};
		end else if (hit_guard) begin
			next_readdata = {8'h00, sector_guard};
		end else if (hit_page) begin
			next_readdata = {7'h00, target_page, 3'h0};
		end
	end

	// read data taken at the taking edge, stands until the next read
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_readdata <= 16'h0000;
		end else if (req && i_read) begin
			o_readdata <= next_readdata;
		end
	end

	// waitrequest high unless answering
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_waitrequest <= 1'b1;
		end else begin
			o_waitrequest <= ~req;
		end
	end

	// ==================== array control ====================
	// any operation in the coming cycle
	assign op_next = next_state == FCR_PROG || next_state == FCR_PERASE || next_state == FCR_MERASE;

	// word program level, high for the whole operation
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_array_prog <= 1'b0;
		end else begin
			o_array_prog <= next_state == FCR_PROG;
		end
	end

	// page erase level
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_array_page_erase <= 1'b0;
		end else begin
			o_array_page_erase <= next_state == FCR_PERASE;
		end
	end

	// mass erase level
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_array_mass_erase <= 1'b0;
		end else begin
			o_array_mass_erase <= next_state == FCR_MERASE;
		end
	end

	// busy while any operation runs
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= op_next;
		end
	end

	// word address latched when a program write is accepted
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_array_addr <= '0;
		end else if (state == FCR_OPEN && next_state == FCR_PROG) begin
			o_array_addr <= i_mem_addr;
		end
	end

	// program word when accepted; erase word is all ones
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_array_data <= FCR_ERASED_WORD;
		end else if (state == FCR_OPEN && next_state == FCR_PROG) begin
			o_array_data <= i_mem_data;
		end else if (next_state == FCR_PERASE || next_state == FCR_MERASE) begin
			o_array_data <= FCR_ERASED_WORD;
		end
	end

	// page follows the selection, frozen while an operation runs
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_array_page <= FCR_PAGE_RST;
		end else if (!o_busy) begin
			o_array_page <= target_page;
		end
	end

	// fetch address falls in the overlaid low 128 bytes
	assign side_hit_next = side_area_select && i_fetch_addr <= FCR_SIDE_AREA_TOP;

	// overlay hit, one cycle behind the fetch address
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_side_area_hit <= 1'b0;
		end else begin
			o_side_area_hit <= side_hit_next;
		end
	end
endmodule // fcr_flash_regs

// ==== fcr_flash_regs_assertions.sv ====
// port checks for the flash controller register front end
`timescale 1ns/1ps
module fcr_flash_regs_assertions
	import fcr_pkg::*;
#(parameter int ADDR_W = 24) (
	// clock, reset and bus
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [ADDR_W-1:0] i_address,
	input wire logic [15:0] o_readdata,
	input wire logic o_waitrequest,
	// array side and overlay
	input wire logic i_array_done,
	input wire logic o_array_prog,
	input wire logic o_array_page_erase,
	input wire logic o_array_mass_erase,
	input wire logic [ADDR_W-1:0] o_array_addr,
	input wire logic [15:0] o_array_data,
	input wire logic [5:0] o_array_page,
	input wire logic [ADDR_W-1:0] i_fetch_addr,
	input wire logic o_side_area_hit,
	input wire logic o_busy
);
	// ==================== properties ====================
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	// status read being answered
	wire stat_rd = !o_waitrequest && i_read && i_address == FCR_ADDR_CMD_STAT;
	a_bus_answer: assert property ($rose(i_read | i_write) |-> ##[1:2] !o_waitrequest)
		else $error("request not answered");
	a_answer_once: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("answer too long");
	a_rsv_zero: assert property (stat_rd |-> !o_readdata[6])
		else $error("status bit 6 set");
	a_idle_zero: assert property (stat_rd && !o_busy && !$past(o_busy) && !$past(o_busy, 2)
		|-> o_readdata[5:0] == FCR_STATE_IDLE) else $error("idle field not zero");
	a_one_op: assert property ($onehot0({o_array_prog, o_array_page_erase, o_array_mass_erase}))
		else $error("two operations at once");
	a_erase_ones: assert property (o_array_page_erase |-> o_array_data == FCR_ERASED_WORD)
		else $error("erase data not all ones");
	a_done_idle: assert property (o_busy && i_array_done |=> !o_busy)
		else $error("busy after completion");
	a_side_hit: assert property (o_side_area_hit |-> $past(i_fetch_addr) <= FCR_SIDE_AREA_TOP)
		else $error("overlay hit out of range");
	a_prog_page: assert property (o_array_prog |-> o_array_addr[16:11] == o_array_page)
		else $error("program outside page");
endmodule // fcr_flash_regs_assertions
bind fcr_flash_regs fcr_flash_regs_assertions #(.ADDR_W(ADDR_W)) u_fcr_chk (.*);

// ==== fcr_array_model.sv ====
// flash array stand-in answering each operation after a fixed delay
`timescale 1ns/1ps
module fcr_array_model #(parameter int LAT = 12) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// operation levels and completion
	input wire logic i_op,
	output logic o_done
);
	int cnt;
	// count while busy, one pulse at the end, then hold until the level drops
	always_ff @(posedge i_clock) begin
		cnt <= (!i_rst_b || !i_op) ? 0 : (cnt > LAT ? cnt : cnt + 1);
	end
	assign o_done = (cnt == LAT);
endmodule // fcr_array_model

// ==== fcr_flash_regs_tb.sv ====
// self-checking bench for the flash controller register front end
`timescale 1ns/1ps
module fcr_flash_regs_tb;
	import fcr_pkg::*;
	logic i_clock = 0, i_rst_b = 0, i_read = 0, i_write = 0, i_mem_wr = 0, i_array_done;
	logic [1:0] i_byteenable = 0;
	logic [23:0] i_address = 0, i_mem_addr = 0, i_fetch_addr = 0, o_array_addr;
	logic [15:0] i_writedata = 0, i_mem_data = 0, o_readdata, o_array_data, q;
	logic [5:0] o_array_page;
	logic o_waitrequest, o_array_prog, o_array_page_erase, o_array_mass_erase;
	logic o_side_area_hit, o_busy;
	int fail_count = 0, n_compared = 0;
	// ==================== clock, design and array ====================
	always #12.5 i_clock = ~i_clock;
	fcr_flash_regs dut (.*);
	fcr_array_model u_arr (.i_clock(i_clock), .i_rst_b(i_rst_b), .o_done(i_array_done),
		.i_op(o_array_prog | o_array_page_erase | o_array_mass_erase));
	// ==================== helpers ====================
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [23:0] a, input logic [15:0] d);
		int n;
		n = 0;
		i_write <= w;
		i_read <= !w;
		i_address <= a;
		i_writedata <= d;
		i_byteenable <= {a[0] | a[2], !a[0]};
		do begin
			@(posedge i_clock);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 40);
		if (o_waitrequest !== 1'b0) begin
			fail_count++;
			final_report;
		end
		q = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic rd(input logic [23:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		chk("register read", a[0] ? q[15:8] : (a[2] ? q : q[7:0]), e);
	endtask
	task automatic busy(input logic v);
		for (int n = 0; n < 200 && o_busy !== v; n++) @(posedge i_clock);
		if (o_busy !== v) begin
			fail_count++;
			final_report;
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		bus(1'b1, FCR_ADDR_CMD_STAT, {8'h00, c});
	endtask
	// ==================== scenarios ====================
	task automatic t_regs;
		rd(FCR_ADDR_CMD_STAT, 16'h0000);
		rd(FCR_ADDR_GUARD, 16'h0000);
		rd(24'hFFE070, 16'h0000);
		bus(1'b1, FCR_ADDR_PAGE, 16'hFFFF);
		rd(FCR_ADDR_PAGE, 16'h01F8);
		bus(1'b1, FCR_ADDR_ACCESS, 16'h8000);
		rd(FCR_ADDR_ACCESS, 16'h0080);
		i_fetch_addr <= 24'h00007F;
		repeat (2) @(posedge i_clock);
		chk("overlay hit", o_side_area_hit, 16'h0001);
		i_fetch_addr <= 24'h000080;
		repeat (2) @(posedge i_clock);
		chk("overlay hit", o_side_area_hit, 16'h0000);
		$display("register test done");
	endtask
	task automatic t_prog;
		bus(1'b1, FCR_ADDR_PAGE, 16'h0010);
		cmd(FCR_CMD_UNLOCK1);
		cmd(FCR_CMD_UNLOCK2);
		rd(FCR_ADDR_CMD_STAT, 16'h0080);
		i_mem_wr <= 1'b1;
		i_mem_addr <= 24'h001006;
		i_mem_data <= 16'h1234;
		@(posedge i_clock);
		i_mem_wr <= 1'b0;
		busy(1'b1);
		chk("array data", o_array_data, 16'h1234);
		chk("array page", o_array_page, 16'h0002);
		chk("array address", o_array_addr[15:0], 16'h1006);
		chk("program level", o_array_prog, 16'h0001);
		rd(FCR_ADDR_CMD_STAT, 16'h0088);
		busy(1'b0);
		rd(FCR_ADDR_CMD_STAT, 16'h0080);
		cmd(FCR_CMD_LOCK);
		rd(FCR_ADDR_CMD_STAT, 16'h0000);
		$display("program test done");
	endtask
	task automatic t_erase(input logic [7:0] c, input logic [15:0] st);
		cmd(FCR_CMD_UNLOCK1);
		cmd(FCR_CMD_UNLOCK2);
		cmd(c);
		busy(1'b1);
		chk("erase kind", {o_array_page_erase, o_array_mass_erase}, {c == 8'h95, c == 8'h63});
		chk("erase data", o_array_data, FCR_ERASED_WORD);
		rd(FCR_ADDR_CMD_STAT, st);
		busy(1'b0);
		rd(FCR_ADDR_CMD_STAT, 16'h0000);
		$display("erase test done");
	endtask
	task automatic t_bad;
		cmd(FCR_CMD_UNLOCK1);
		cmd(FCR_CMD_PAGE_ERASE);
		cmd(FCR_CMD_UNLOCK2);
		rd(FCR_ADDR_CMD_STAT, 16'h0000);
		cmd(FCR_CMD_UNLOCK1);
		cmd(FCR_CMD_UNLOCK2);
		cmd(8'h55);
		rd(FCR_ADDR_CMD_STAT, 16'h0000);
		cmd(FCR_CMD_UNLOCK1);
		bus(1'b1, FCR_ADDR_PAGE, 16'h0000);
		cmd(FCR_CMD_UNLOCK2);
		rd(FCR_ADDR_CMD_STAT, 16'h0000);
		bus(1'b1, FCR_ADDR_GUARD, 16'h0001);
		bus(1'b1, FCR_ADDR_GUARD, 16'h0000);
		rd(FCR_ADDR_GUARD, 16'h0001);
		bus(1'b1, FCR_ADDR_PAGE, 16'h0000);
		cmd(FCR_CMD_UNLOCK1);
		cmd(FCR_CMD_UNLOCK2);
		cmd(FCR_CMD_PAGE_ERASE);
		rd(FCR_ADDR_CMD_STAT, 16'h0000);
		chk("busy", o_busy, 16'h0000);
		cmd(FCR_CMD_UNLOCK1);
		cmd(FCR_CMD_UNLOCK2);
		cmd(FCR_CMD_MASS_ERASE);
		rd(FCR_ADDR_CMD_STAT, 16'h0000);
		cmd(FCR_CMD_UNLOCK1);
		cmd(FCR_CMD_UNLOCK2);
		i_mem_wr <= 1'b1;
		i_mem_addr <= 24'h000010;
		@(posedge i_clock);
		i_mem_wr <= 1'b0;
		repeat (2) @(posedge i_clock);
		chk("guarded program", o_busy, 16'h0000);
		rd(FCR_ADDR_CMD_STAT, 16'h0080);
		cmd(FCR_CMD_LOCK);
		$display("sequence and guard test done");
	endtask
	// ==================== main sequence ====================
	initial begin
		repeat (3) @(posedge i_clock);
		i_rst_b <= 1'b1;
		@(posedge i_clock);
		t_regs;
		t_prog;
		t_erase(FCR_CMD_PAGE_ERASE, 16'h0090);
		t_erase(FCR_CMD_MASS_ERASE, 16'h00A0);
		t_bad;
		final_report;
	end
endmodule // fcr_flash_regs_tb
